// ### design/input_filter.sv
// Three-stage synchroniser and stability filter for one discrete input pin
`timescale 1ns/100ps
module input_filter #(
  parameter int STABLE_CYCLES = 200
) (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      level_q
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);

  logic          s1_q;
  logic          s2_q;
  logic          s3_q;
  logic [CW-1:0] cnt_q;

  // Open pin idles high, so the chain resets to high
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Contact bounce restarts the count; only a settled level passes
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q   <= '0;
      level_q <= 1'b1;
    end else if (s2_q != s3_q || s3_q == level_q) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(STABLE_CYCLES - 1)) begin
      cnt_q   <= '0;
      level_q <= s3_q;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  settle_a: assert property (
    @(posedge clk_sys) disable iff (!resetn)
    (level_q != $past(level_q)) |-> ($past(s3_q) == level_q && $past(s2_q) == level_q))
    else $error("filtered level changed before inputs agreed");

endmodule

// ### design/servo_sel_pkg.sv
// Shared constants for the speed source select and drive enable logic
package servo_sel_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 200_000_000;
  localparam int CLK_PERIOD_NS   = 5;
  localparam int POWERON_MS      = 2000;
  localparam int POWERON_CYCLES  = POWERON_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_NS     = 1000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_GEAR1    = 8'h08;
  localparam logic [7:0]  ADDR_GEAR2    = 8'h0c;
  localparam logic [7:0]  ADDR_PRESET   = 8'h10;
  localparam logic [7:0]  ADDR_PRESET_END = 8'h30;
  localparam int          PRESET_COUNT  = 8;

  // Control register fields
  localparam int          CTRL_MODE_LSB = 0;
  localparam int          CTRL_SRC_LSB  = 2;
  localparam int          CTRL_SEQ_LSB  = 4;
  localparam logic [31:0] CTRL_MASK     = 32'h0000_003f;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
  localparam int          SEQ_BRAKE_BIT = 0;
  localparam int          SEQ_CLEAR_BIT = 1;

  // Status register fields
  localparam int          ST_READY      = 0;
  localparam int          ST_SERVO      = 1;
  localparam int          ST_ANALOG     = 2;
  localparam int          ST_IDX_LSB    = 3;
  localparam int          ST_IN_LSB     = 6;

  localparam logic [31:0] GEAR_RESET    = 32'h0000_0001;
  localparam logic [31:0] PRESET_RESET  = 32'h0000_0000;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    MODE_POSITION,
    MODE_VELOCITY,
    MODE_TORQUE,
    MODE_FULL_CLOSED
  } ctrl_mode_t;

endpackage

// ### design/servo_speed_source_select.sv
// Speed source decode, gear select and drive enable gating with register slave
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
module servo_speed_source_select
  import servo_sel_pkg::*;
#(
  parameter int SPEED_W        = 16,
  parameter int GEAR_W         = 16,
  parameter int POWERON_CYC    = POWERON_CYCLES,
  parameter int DEBOUNCE_CYC   = DEBOUNCE_CYCLES
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]         awprot,
  input  wire logic               wvalid,
  output logic                    wready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  output logic                    bvalid,
  input  wire logic               bready,
  output logic [1:0]              bresp,
  input  wire logic               arvalid,
  output logic                    arready,
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic [2:0]         arprot,
  output logic                    rvalid,
  input  wire logic               rready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  input  wire logic               speed_sel_bit0_n,
  input  wire logic               speed_sel_bit1_n,
  input  wire logic               speed_sel_bit2_n,
  input  wire logic               drive_enable_input_n,
  input  wire logic [SPEED_W-1:0] analog_speed_cmd,
  output logic [SPEED_W-1:0]      speed_cmd_q,
  output logic                    use_analog_q,
  output logic [2:0]              preset_index_q,
  output logic [GEAR_W-1:0]       gear_numerator_q,
  output logic                    servo_on_q,
  output logic                    dyn_brake_q,
  output logic                    deviation_clear_q
);

  localparam int PCW = $clog2(POWERON_CYC + 1);

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [3:0] pins;
  logic [3:0] filt;
  logic [2:0] sel;
  logic       enable_in;

  assign pins = {drive_enable_input_n, speed_sel_bit2_n,
                 speed_sel_bit1_n, speed_sel_bit0_n};

  for (genvar i = 0; i < 4; i++) begin : g_filt
    input_filter #(
      .STABLE_CYCLES (DEBOUNCE_CYC)
    ) u_filt (
      .clk_sys (clk_sys),
      .resetn  (resetn),
      .pin     (pins[i]),
      .level_q (filt[i])
    );
  end

  // Shorted to common reads low, so asserted is the inverse
  assign sel       = ~filt[2:0];
  assign enable_in = ~filt[3];

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0]        ctrl_q;
  logic [GEAR_W-1:0]  gear1_q;
  logic [GEAR_W-1:0]  gear2_q;
  logic [SPEED_W-1:0] preset_q [PRESET_COUNT];
  ctrl_mode_t         mode;
  logic [1:0]         src;
  logic [1:0]         seq;

  assign mode = ctrl_mode_t'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign src  = ctrl_q[CTRL_SRC_LSB +: 2];
  assign seq  = ctrl_q[CTRL_SEQ_LSB +: 2];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_preset(input logic [ADDR_W-1:0] a);
    return a >= ADDR_PRESET && a < ADDR_PRESET_END && a[1:0] == 2'b00;
  endfunction

  function automatic logic [2:0] preset_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] off;
    off = a - ADDR_PRESET;
    return off[4:2];
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [31:0]       wr_data_q;
  logic [3:0]        wr_strb_q;
  logic              commit;
  logic              wr_ok;

  assign commit = aw_have_q && w_have_q && !bvalid;
  assign wr_ok  = wr_addr_q == ADDR_CTRL || wr_addr_q == ADDR_STATUS ||
                  wr_addr_q == ADDR_GEAR1 || wr_addr_q == ADDR_GEAR2 ||
                  is_preset(wr_addr_q);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_have_q <= 1'b0;
      awready   <= 1'b1;
      wr_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awready   <= 1'b0;
      wr_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      aw_have_q <= 1'b0;
      awready   <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      w_have_q  <= 1'b0;
      wready    <= 1'b1;
      wr_data_q <= '0;
      wr_strb_q <= '0;
    end else if (wvalid && wready) begin
      w_have_q  <= 1'b1;
      wready    <= 1'b0;
      wr_data_q <= wdata;
      wr_strb_q <= wstrb;
    end else if (bvalid && bready) begin
      w_have_q <= 1'b0;
      wready   <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (commit) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Status is read-only; a write there is accepted and dropped
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= CTRL_RESET;
      gear1_q <= GEAR_W'(GEAR_RESET);
      gear2_q <= GEAR_W'(GEAR_RESET);
      for (int i = 0; i < PRESET_COUNT; i++) begin
        preset_q[i] <= SPEED_W'(PRESET_RESET);
      end
    end else if (commit) begin
      if (wr_addr_q == ADDR_CTRL) begin
        ctrl_q <= merge(ctrl_q, wr_data_q, wr_strb_q) & CTRL_MASK;
      end
      if (wr_addr_q == ADDR_GEAR1) begin
        gear1_q <= GEAR_W'(merge(32'(gear1_q), wr_data_q, wr_strb_q));
      end
      if (wr_addr_q == ADDR_GEAR2) begin
        gear2_q <= GEAR_W'(merge(32'(gear2_q), wr_data_q, wr_strb_q));
      end
      if (is_preset(wr_addr_q)) begin
        preset_q[preset_slot(wr_addr_q)] <=
          SPEED_W'(merge(32'(preset_q[preset_slot(wr_addr_q)]), wr_data_q, wr_strb_q));
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  logic ready_q;

  function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a);
    logic [31:0] st;
    st = '0;
    st[ST_READY]            = ready_q;
    st[ST_SERVO]            = servo_on_q;
    st[ST_ANALOG]           = use_analog_q;
    st[ST_IDX_LSB +: 3]     = preset_index_q;
    st[ST_IN_LSB +: 4]      = ~filt;
    if (a == ADDR_CTRL)   return {1'b1, ctrl_q};
    if (a == ADDR_STATUS) return {1'b1, st};
    if (a == ADDR_GEAR1)  return {1'b1, 32'(gear1_q)};
    if (a == ADDR_GEAR2)  return {1'b1, 32'(gear2_q)};
    if (is_preset(a))     return {1'b1, 32'(preset_q[preset_slot(a)])};
    return {1'b0, 32'h0000_0000};
  endfunction

  logic [32:0] rd_word;

  always_comb begin
    rd_word = read_word(araddr);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word[31:0];
      rresp   <= rd_word[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Speed source and gear decode
  // ----------------------------------------------------------------
  logic              analog_d;
  logic [2:0]        idx_d;
  logic [GEAR_W-1:0] gear_d;

  // Decoded every cycle from filtered inputs; the registered outputs follow one clock later
  always_comb begin
    analog_d = 1'b1;
    idx_d    = 3'h0;
    gear_d   = gear1_q;
    case (mode)
      MODE_VELOCITY: begin
        case (src)
          2'd0: analog_d = 1'b1;
          2'd1: begin
            analog_d = 1'b0;
            idx_d    = {1'b0, sel[1:0]};
          end
          2'd2: begin
            analog_d = &sel[1:0];
            idx_d    = {1'b0, sel[1:0]};
          end
          2'd3: begin
            analog_d = 1'b0;
            idx_d    = sel;
          end
          default: analog_d = 1'b1;
        endcase
      end
      MODE_POSITION, MODE_FULL_CLOSED: begin
        gear_d = sel[2] ? gear2_q : gear1_q;
      end
      MODE_TORQUE: analog_d = 1'b1;
      default: analog_d = 1'b1;
    endcase
  end

  // Slots 4..7 are the upper preset group at their own addresses
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      use_analog_q     <= 1'b1;
      preset_index_q   <= 3'h0;
      speed_cmd_q      <= '0;
      gear_numerator_q <= GEAR_W'(GEAR_RESET);
    end else begin
      use_analog_q     <= analog_d;
      preset_index_q   <= idx_d;
      speed_cmd_q      <= analog_d ? analog_speed_cmd : preset_q[idx_d];
      gear_numerator_q <= gear_d;
    end
  end

  // ----------------------------------------------------------------
  // Drive enable gating
  // ----------------------------------------------------------------
  logic [PCW-1:0] pon_cnt_q;
  logic           servo_d;

  // Power-on hold-off before drive enable is honoured
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pon_cnt_q <= '0;
      ready_q   <= 1'b0;
    end else if (!ready_q) begin
      if (pon_cnt_q == PCW'(POWERON_CYC - 1)) begin
        ready_q <= 1'b1;
      end else begin
        pon_cnt_q <= pon_cnt_q + 1'b1;
      end
    end
  end

  assign servo_d = ready_q && enable_in;

  // Host may not use enable to start or stop motion; no ramp is applied here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      servo_on_q        <= 1'b0;
      dyn_brake_q       <= 1'b0;
      deviation_clear_q <= 1'b0;
    end else begin
      servo_on_q        <= servo_d;
      deviation_clear_q <= servo_on_q && !servo_d && seq[SEQ_CLEAR_BIT];
      if (servo_d) begin
        dyn_brake_q <= 1'b0;
      end else if (servo_on_q) begin
        dyn_brake_q <= seq[SEQ_BRAKE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  src0_analog_a: assert property (
    (mode == MODE_VELOCITY && src == 2'd0) |=> use_analog_q)
    else $error("source 0 did not select analog");

  src1_index_a: assert property (
    (mode == MODE_VELOCITY && src == 2'd1)
    |=> (!use_analog_q && preset_index_q == {1'b0, $past(sel[1:0])}))
    else $error("source 1 preset index wrong");

  src2_both_a: assert property (
    (mode == MODE_VELOCITY && src == 2'd2)
    |=> (use_analog_q == (&$past(sel[1:0]))))
    else $error("source 2 analog choice wrong");

  src3_preset_a: assert property (
    (mode == MODE_VELOCITY && src == 2'd3)
    |=> (preset_index_q == $past(sel) && speed_cmd_q == $past(preset_q[sel])))
    else $error("source 3 preset value wrong");

  gear_select_a: assert property (
    ((mode == MODE_POSITION || mode == MODE_FULL_CLOSED) && sel[2])
    |=> gear_numerator_q == $past(gear2_q))
    else $error("second gear numerator not used");

  torque_ignore_a: assert property (
    (mode == MODE_TORQUE) |=> (use_analog_q && gear_numerator_q == $past(gear1_q)))
    else $error("select bit 2 acted in torque mode");

  poweron_hold_a: assert property (
    !ready_q |-> ##1 !servo_on_q)
    else $error("servo on before power-on delay");

  servo_on_a: assert property (
    (ready_q && enable_in) |=> servo_on_q)
    else $error("servo on not entered");

  servo_off_a: assert property (
    !enable_in |=> (!servo_on_q ##1 !servo_on_q || enable_in))
    else $error("servo off not entered");

  off_sequence_a: assert property (
    (servo_on_q && !servo_d)
    |=> (dyn_brake_q == $past(seq[SEQ_BRAKE_BIT])
         && deviation_clear_q == $past(seq[SEQ_CLEAR_BIT])))
    else $error("servo-off sequence wrong");

endmodule

// ### tb/host_ctrl_model.sv
// Host controller model driving the discrete select and enable pins
`timescale 1ns/100ps
module host_ctrl_model #(
  parameter int SETTLE_CYC = 8
) (
  input  wire logic       clk_sys,
  input  wire logic [2:0] sel_req,
  input  wire logic       enable_req,
  input  wire logic       glitch_req,
  output logic [2:0]      sel_n,
  output logic            enable_n
);
  logic [7:0] settle_q = 8'h00;

  // ----------------------------------------------------------------
  // Pins, low means shorted to common
  // ----------------------------------------------------------------
  // Enable only follows the bench; motion is set by speed selection
  always_ff @(posedge clk_sys) enable_n <= ~enable_req;

  always_ff @(posedge clk_sys) begin
    if (enable_req && enable_n) begin
      settle_q <= 8'h00;
    end else if (settle_q != 8'(SETTLE_CYC)) begin
      settle_q <= settle_q + 8'h01;
    end
  end

  // Select changes wait out the pause after enable
  always_ff @(posedge clk_sys) begin
    if (!enable_req || settle_q == 8'(SETTLE_CYC)) begin
      sel_n <= ~sel_req ^ {2'b00, glitch_req};
    end
  end
endmodule

// ### tb/servo_speed_source_select_test.sv
// Self-checking bench for speed source select and drive enable gating
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module servo_speed_source_select_test;
  import servo_sel_pkg::*;
  typedef struct {
    logic vel; logic gchk; logic [15:0] spd; logic ana; logic [2:0] idx;
    logic [15:0] gear; logic son; logic brk; int dcn;
  } note_t;

  logic        clk_sys = 1'b0, resetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hf;
  logic [15:0] analog = 16'h0;
  logic [2:0]  sel_req = 3'b000;
  logic        enable_req = 1'b0, glitch_req = 1'b0, chk_req = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, use_analog_q, servo_on_q;
  logic        dyn_brake_q, deviation_clear_q, enable_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, seed = 32'h1637;
  logic [15:0] speed_cmd_q, gear_numerator_q, g1, g2;
  logic [15:0] pre [8];
  logic [2:0]  preset_index_q, sel_n;
  int          err_total = 0, comparisons = 0, cycles = 0, dc_cnt = 0;
  logic [1:0]  bq [$];
  logic [33:0] rq [$];
  note_t       oq [$];
  note_t       n;
  note_t       got;

  initial forever #2.5 clk_sys = ~clk_sys;

  host_ctrl_model #(.SETTLE_CYC(8)) host (.clk_sys(clk_sys), .sel_req(sel_req),
    .enable_req(enable_req), .glitch_req(glitch_req), .sel_n(sel_n), .enable_n(enable_n));

  servo_speed_source_select #(.POWERON_CYC(50), .DEBOUNCE_CYC(4)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'b000), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'b000), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .speed_sel_bit0_n(sel_n[0]), .speed_sel_bit1_n(sel_n[1]),
    .speed_sel_bit2_n(sel_n[2]), .drive_enable_input_n(enable_n),
    .analog_speed_cmd(analog), .speed_cmd_q(speed_cmd_q), .use_analog_q(use_analog_q),
    .preset_index_q(preset_index_q), .gear_numerator_q(gear_numerator_q),
    .servo_on_q(servo_on_q), .dyn_brake_q(dyn_brake_q),
    .deviation_clear_q(deviation_clear_q));

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic final_report();
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Bus master tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    @(posedge clk_sys);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge clk_sys);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask

  // Wait past sync and debounce, then ask the monitor to compare
  task automatic check(input note_t e);
    repeat (24) @(posedge clk_sys);
    oq.push_back(e);
    chk_req <= 1'b1;
    @(posedge clk_sys);
    chk_req <= 1'b0;
  endtask

  task automatic vel(input int src, input logic [2:0] s);
    logic [2:0]  k;
    logic [15:0] a16;
    k = (src == 3) ? s : {1'b0, s[1:0]};
    a16 = 16'(rnd());
    wr(ADDR_CTRL, 32'(src * 4 + 1), RESP_OKAY);
    sel_req <= s;
    analog <= a16;
    n.vel = 1'b1; n.gchk = 1'b0; n.idx = k;
    n.ana = (src == 0) || (src == 2 && s[1:0] == 2'b11);
    n.spd = n.ana ? a16 : pre[k];
    check(n);
  endtask

  // ----------------------------------------------------------------
  // Result monitor
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles >= 20000) begin
      err_total++;
      final_report();
    end
    if (deviation_clear_q === 1'b1) dc_cnt++;
    if (bvalid && bready) `CHK(bresp, bq.pop_front())
    if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
    if (chk_req) begin
      got = oq.pop_front();
      if (got.vel) begin
        `CHK(use_analog_q, got.ana)
        `CHK(speed_cmd_q, got.spd)
        if (!got.ana) `CHK(preset_index_q, got.idx)
      end
      if (got.gchk) `CHK(gear_numerator_q, got.gear)
      `CHK(servo_on_q, got.son)
      `CHK(dyn_brake_q, got.brk)
      `CHK(dc_cnt, got.dcn)
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    enable_req <= 1'b1;
    n = '{1'b1, 1'b1, 16'h0, 1'b1, 3'd0, 16'h1, 1'b0, 1'b0, 0};
    check(n);
    rd(ADDR_CTRL, CTRL_RESET, RESP_OKAY);
    rd(ADDR_GEAR2, GEAR_RESET, RESP_OKAY);
    rd(ADDR_PRESET, PRESET_RESET, RESP_OKAY);
    rd(8'h40, 32'h0, RESP_SLVERR);
    wr(8'h40, 32'h5, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hffff_ffff, RESP_OKAY);
    repeat (20) @(posedge clk_sys);
    n.son = 1'b1;
    check(n);
    rd(ADDR_STATUS, 32'((1 << ST_READY) | (1 << ST_SERVO) | (1 << ST_ANALOG)
                        | (8 << ST_IN_LSB)), RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      pre[i] = 16'(rnd());
      wr(ADDR_PRESET + 8'(4 * i), {16'h0, pre[i]}, RESP_OKAY);
    end
    g1 = 16'(rnd()) | 16'h1;
    g2 = {8'ha5, 8'(rnd())} | 16'h2;
    wr(ADDR_GEAR1, {16'h0, g1}, RESP_OKAY);
    wr(ADDR_GEAR2, {16'h0, g2}, RESP_OKAY);
    rd(ADDR_GEAR2, {16'h0, g2}, RESP_OKAY);
    // Byte strobes: only the upper byte of the first numerator moves
    wstrb <= 4'h2;
    wr(ADDR_GEAR1, 32'h0000_5a00, RESP_OKAY);
    wstrb <= 4'hf;
    g1[15:8] = 8'h5a;
    rd(ADDR_GEAR1, {16'h0, g1}, RESP_OKAY);
    for (int src = 0; src < 4; src++) begin
      for (int s = 0; s < 8; s++) vel(src, 3'(s));
    end
    // Short pulse on a select pin must not move the selection
    vel(3, 3'd0);
    glitch_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    glitch_req <= 1'b0;
    check(n);
    n.vel = 1'b0; n.gchk = 1'b1;
    for (int m = 0; m < 4; m++) begin
      if (m == 1) continue;
      for (int s2 = 0; s2 < 2; s2++) begin
        wr(ADDR_CTRL, 32'(m), RESP_OKAY);
        sel_req <= {s2[0], 2'b00};
        n.gear = (m != 2 && s2 == 1) ? g2 : g1;
        check(n);
      end
    end
    n.gchk = 1'b0;
    wr(ADDR_CTRL, 32'h31, RESP_OKAY);
    enable_req <= 1'b0;
    n.son = 1'b0; n.brk = 1'b1; n.dcn = 1;
    check(n);
    enable_req <= 1'b1;
    n.son = 1'b1; n.brk = 1'b0;
    check(n);
    wr(ADDR_CTRL, 32'h01, RESP_OKAY);
    enable_req <= 1'b0;
    n.son = 1'b0;
    check(n);
    // Let the monitor finish the last comparison first
    @(posedge clk_sys);
    final_report();
  end
endmodule
